// [shared/sar_pkg.sv]
// Purpose: shared constants of the serial readout converter block
// Assumes: core clock of 125 MHz
// Notes:   register offsets are byte addresses on the bus
package sar_pkg;
    // ********************************************************
    // resolution and timing
    // ********************************************************
    localparam int CODE_W        = 16;
    localparam int CLK_MHZ       = 125;
    localparam int CONV_MAX_NS   = 322;
    localparam int CONV_MAX_CYC  = (CONV_MAX_NS * CLK_MHZ) / 1000;
    localparam int BIT_CYC       = CONV_MAX_CYC / (CODE_W + 2);
    localparam int CNT_W         = 6;
    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_RESULT = 5'h08;
    localparam logic [4:0] OFS_IRQ_ST = 5'h0c;
    localparam logic [4:0] OFS_IRQ_MK = 5'h10;
    localparam int CTRL_GO_BIT    = 0;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_CHAIN_BIT = 1;
    localparam int STAT_AWAKE_BIT = 2;
    localparam int IRQ_W          = 3;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_REFUSE_BIT = 1;
    localparam int IRQ_WORD_BIT   = 2;
    localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 3'h0;
    localparam logic [CODE_W-1:0] CODE_RST     = 16'h0000;
    localparam logic [CODE_W-1:0] TRIAL_TOP    = 16'h8000;
    localparam logic [31:0]       RDATA_RST    = 32'h0000_0000;
    localparam logic [4:0]        WORD_LAST    = 5'h0f;
    typedef enum logic [1:0] {ST_ACQUIRE, ST_CONVERT, ST_LOAD} conv_state_t;
endpackage : sar_pkg

// [hdl/sync2.sv]
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk
// Notes:   first stage read only by the second
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1)
    begin : g_width_check
        $error("synchroniser needs at least one bit");
    end
    // ********************************************************
    // one pair of flops per bit
    // ********************************************************
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge core_clk)
        begin
            if (rst)
            begin
                meta_q[i]   <= 1'b0;
                pin_sync[i] <= 1'b0;
            end
            else
            begin
                meta_q[i]   <= pin_in[i];
                pin_sync[i] <= meta_q[i];
            end
        end
    end
endmodule : sync2

// [hdl/sar_adc_serial_readout.sv]
// Purpose: conversion control and serial readout of a 16-bit SAR converter
// Assumes: pins sampled by core_clk; analog_level is the sampled input level
// Notes:   Avalon-MM slave with one wait state per access
//
// What this block does and what its host must do
// RULE1: chain_select low makes the shared pin an active-low output enable.
// RULE2: chain_select high makes the shared pin the upstream serial input.
// RULE3: a rising convert_start edge wakes the block and starts a conversion.
// RULE4: busy rises as a conversion starts and falls once it has finished.
// RULE5: each rising shift clock edge moves out one bit, top bit first.
// RULE6: the code is straight binary with zero at the bottom of the range.
// RULE7: a 16-step successive approximation search from half to 1/65536.
// RULE8: acquisition samples the input until the convert edge ends it.
// RULE9: the finished code is loaded into the serial shift path.
// RULE10: each result is ready in its own conversion cycle, no latency.
// RULE11: conversion steps come from an internal divider, not the host.
// RULE12: the block sleeps whenever it is not converting.
// RULE13: a conversion never takes longer than its maximum time.
// RULE14: the host moves convert_start again only early or after busy falls.
// RULE15: output changes on the rising edge, top bit valid until the first.
// RULE16: the host waits out the reinitialisation time after power-on.
// RULE17: in chain mode upstream bits follow the own result out.
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module sar_adc_serial_readout (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic [4:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       convert_start,
    input  wire logic                       chain_select,
    input  wire logic                       bus_enable_or_link_in,
    input  wire logic                       shift_clk,
    input  wire logic [sar_pkg::CODE_W-1:0] analog_level,
    output logic                            busy,
    output logic                            serial_out,
    output logic                            serial_out_oe,
    output logic                            irq
);
    import sar_pkg::*;

    if (BIT_CYC < 1 || (CODE_W + 2) * BIT_CYC > CONV_MAX_CYC)
    begin : g_rate_check
        $error("conversion step rate cannot meet the maximum time");
    end

    typedef struct packed {
        conv_state_t         st;
        logic [CNT_W-1:0]    div;
        logic [CNT_W-1:0]    conv_cnt;
        logic [CODE_W-1:0]   sample;
        logic [CODE_W-1:0]   sar;
        logic [CODE_W-1:0]   trial;
        logic [CODE_W-1:0]   shreg;
        logic [4:0]          shift_cnt;
        logic [CODE_W-1:0]   result;
        logic                cnv_prev;
        logic                sck_prev;
        logic                busy;
        logic                oe;
        logic                waitreq;
        logic [31:0]         rdata;
        logic [IRQ_W-1:0]    irq_st;
        logic [IRQ_W-1:0]    irq_mk;
        logic                irq;
    } state_t;

    state_t           q;
    state_t           d;
    logic [3:0]       pin_s;
    logic             cnv_s;
    logic             chain_s;
    logic             link_s;
    logic             sck_s;
    logic             cnv_rise;
    logic             sck_rise;
    logic             tick;
    logic             go;
    logic             req;
    logic             take;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [2:0]       word_sel;

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    // shared pin enters inverted so a reset stage reads idle
    sync2 #(
        .WIDTH    (4)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   ({convert_start, chain_select,
                    ~bus_enable_or_link_in, shift_clk}),
        .pin_sync (pin_s)
    );

    assign cnv_s    = pin_s[3];
    assign chain_s  = pin_s[2];
    assign link_s   = ~pin_s[1];
    assign sck_s    = pin_s[0];
    assign cnv_rise = cnv_s & ~q.cnv_prev;
    assign sck_rise = sck_s & ~q.sck_prev;
    assign req      = avs_read | avs_write;
    assign take     = req & ~q.waitreq;
    assign word_sel = avs_address[4:2];

    // ********************************************************
    // next state
    // ********************************************************
    always_comb
    begin
        d        = q;
        irq_set  = '0;
        irq_clr  = '0;
        d.cnv_prev = cnv_s;
        d.sck_prev = sck_s;
        go = cnv_rise | (take & avs_write & (avs_address == OFS_CTRL)
             & avs_writedata[CTRL_GO_BIT]);
        tick = (q.st == ST_CONVERT) && (q.div == CNT_W'(BIT_CYC - 1)); // RULE11

        // output enable per mode
        d.oe = chain_s ? 1'b1 : ~link_s; // RULE1 RULE2

        // conversion sequencer
        unique case (q.st)
            ST_ACQUIRE:
            begin
                d.conv_cnt = '0;
                if (go)
                begin
                    d.sample = analog_level; // RULE8
                    d.sar    = CODE_RST;
                    d.trial  = TRIAL_TOP; // RULE7
                    d.div    = '0;
                    d.busy   = 1'b1; // RULE3 RULE4 RULE12
                    d.st     = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                d.conv_cnt = q.conv_cnt + 1'b1;
                d.div      = tick ? '0 : q.div + 1'b1; // RULE11
                if (go)
                    irq_set[IRQ_REFUSE_BIT] = 1'b1;
                if (tick)
                begin
                    if (q.sample >= (q.sar | q.trial))
                        d.sar = q.sar | q.trial; // RULE6 RULE7
                    d.trial = q.trial >> 1;
                    if (q.trial[0])
                        d.st = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                d.conv_cnt = q.conv_cnt + 1'b1;
                d.result   = q.sar; // RULE10
                d.busy     = 1'b0; // RULE4 RULE12
                d.st       = ST_ACQUIRE;
                irq_set[IRQ_DONE_BIT] = 1'b1;
                if (go)
                    irq_set[IRQ_REFUSE_BIT] = 1'b1;
            end
            default: d.st = ST_ACQUIRE;
        endcase

        // serial output path
        if (q.st == ST_LOAD)
        begin
            d.shreg     = q.sar; // RULE9
            d.shift_cnt = '0;
        end
        else if (sck_rise) // RULE15
        begin
            d.shreg = {q.shreg[CODE_W-2:0], chain_s & link_s}; // RULE5 RULE17
            d.shift_cnt = q.shift_cnt + 1'b1;
            if (q.shift_cnt == WORD_LAST)
                irq_set[IRQ_WORD_BIT] = 1'b1;
        end

        // bus slave, one wait state
        d.waitreq = 1'b1;
        if (req && q.waitreq)
        begin
            d.waitreq = 1'b0;
            unique case (word_sel)
                3'h0:    d.rdata = RDATA_RST;
                3'h1:    d.rdata = {29'h0000_0000, ~q.busy & 1'b0 | q.busy,
                                    chain_s, q.busy};
                3'h2:    d.rdata = {16'h0000, q.result};
                3'h3:    d.rdata = {29'h0000_0000, q.irq_st};
                3'h4:    d.rdata = {29'h0000_0000, q.irq_mk};
                default: d.rdata = RDATA_RST;
            endcase
        end
        if (take && avs_write)
        begin
            if (avs_address == OFS_IRQ_ST)
                irq_clr = avs_writedata[IRQ_W-1:0];
            if (avs_address == OFS_IRQ_MK)
                d.irq_mk = avs_writedata[IRQ_W-1:0];
        end

        // sticky status, set wins over clear
        d.irq_st = (q.irq_st & ~irq_clr) | irq_set;
        d.irq    = |(q.irq_st & q.irq_mk);
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q         <= '0;
            q.st      <= ST_ACQUIRE;
            q.waitreq <= 1'b1;
            q.irq_mk  <= IRQ_MASK_RST;
        end
        else
            q <= d;
    end

    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.waitreq;
    assign busy            = q.busy;
    assign serial_out      = q.shreg[CODE_W-1];
    assign serial_out_oe   = q.oe;
    assign irq             = q.irq;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    busy_rise_a: assert property ( // RULE3
        (q.st == ST_ACQUIRE) && cnv_rise |=> q.busy)
        else $error("busy did not rise on convert edge");

    busy_fall_a: assert property ( // RULE4
        (q.st == ST_LOAD) |=> !q.busy && (q.st == ST_ACQUIRE))
        else $error("busy did not fall after conversion");

    conv_bound_a: assert property ( // RULE13
        q.conv_cnt <= CNT_W'(CONV_MAX_CYC))
        else $error("conversion ran past its maximum time");

    load_code_a: assert property ( // RULE9
        $fell(q.busy) |-> q.shreg == q.result)
        else $error("finished code not loaded for shifting");

    zero_code_a: assert property ( // RULE6
        (q.st == ST_LOAD) && (q.sample == CODE_RST) |=> q.result == CODE_RST)
        else $error("bottom of range did not give code zero");

    exact_code_a: assert property ( // RULE7
        (q.st == ST_LOAD) |-> q.sar == q.sample)
        else $error("search did not resolve the sample");

    shift_msb_a: assert property ( // RULE5
        sck_rise && (q.st != ST_LOAD) |=>
        q.shreg[CODE_W-1:1] == $past(q.shreg[CODE_W-2:0]))
        else $error("serial path did not shift top bit first");

    chain_pass_a: assert property ( // RULE17
        sck_rise && chain_s && (q.st != ST_LOAD) |=>
        q.shreg[0] == $past(link_s))
        else $error("upstream bit not passed on");

    oe_mode_a: assert property ( // RULE1
        !chain_s ##1 !chain_s |-> q.oe == !$past(link_s))
        else $error("output enable does not follow the shared pin");

    tick_only_a: assert property ( // RULE11
        tick |-> q.busy)
        else $error("conversion step outside a conversion");

    wait_one_a: assert property (
        !q.waitreq |=> q.waitreq)
        else $error("waitrequest low for more than one cycle");

    oe_chain_a: assert property ( // RULE2
        chain_s |=> q.oe)
        else $error("output not enabled in chain mode");

    wake_edge_a: assert property ( // RULE3
        $rose(q.busy) |-> $past(go))
        else $error("conversion started without a start request");

    busy_conv_a: assert property ( // RULE4
        (q.st != ST_ACQUIRE) |-> q.busy)
        else $error("busy low during a conversion");

    sleep_idle_a: assert property ( // RULE12
        (q.st == ST_ACQUIRE) |-> !q.busy)
        else $error("block awake outside a conversion");

    trial_walk_a: assert property ( // RULE7
        (q.st == ST_CONVERT) |-> $onehot(q.trial))
        else $error("trial weight lost during search");

    sample_hold_a: assert property ( // RULE8
        (q.st != ST_ACQUIRE) |=> $stable(q.sample))
        else $error("sample changed during conversion");

    result_load_a: assert property ( // RULE9
        (q.st == ST_LOAD) |=> q.result == $past(q.sar))
        else $error("finished code not taken as result");

    result_hold_a: assert property ( // RULE10
        (q.st != ST_LOAD) |=> $stable(q.result))
        else $error("result changed outside the load step");

    shift_hold_a: assert property ( // RULE15
        !sck_rise && (q.st != ST_LOAD) |=> $stable(q.shreg))
        else $error("serial output moved without a shift edge");

    step_count_a: assert property ( // RULE11
        (q.st == ST_LOAD) |-> q.conv_cnt == CNT_W'(CODE_W * BIT_CYC))
        else $error("conversion took the wrong number of steps");

    irq_level_a: assert property (
        1'b1 |=> q.irq == (|$past(q.irq_st & q.irq_mk)))
        else $error("interrupt does not follow unmasked status");

    set_wins_a: assert property (
        (irq_set != '0) |=>
        ((q.irq_st & $past(irq_set)) == $past(irq_set)))
        else $error("status event lost against a clear");

    conv_done_c: cover property (q.busy ##1 !q.busy);
    chain_word_c: cover property (chain_s && irq_set[IRQ_WORD_BIT]);
    bus_read_c: cover property (take && avs_read);
    refused_c: cover property (irq_set[IRQ_REFUSE_BIT]);
    chain_in_c: cover property (sck_rise && chain_s && link_s);
endmodule : sar_adc_serial_readout

// [test/host_model.sv]
// Purpose: host controller model driving convert, shift clock and shared pin
// Assumes: shift clock period of 125 ns, held low outside frames
// Notes:   each bit is captured just before the next rising shift edge
`timescale 1ns/1ps
module host_model (
    input  wire logic        core_clk,
    input  wire logic        serial_out,
    input  wire logic        chain_mode,
    output logic             convert_start,
    output logic             shift_clk,
    output logic             bus_enable_or_link_in,
    output logic [31:0]      word
);
    event word_ev;
    initial
    begin
        convert_start = 1'b0;
        shift_clk = 1'b0;
        bus_enable_or_link_in = 1'b1;
        word = 32'h0000_0000;
    end
    // ********************************************************
    // convert edge, low again inside the early window
    // ********************************************************
    task automatic convert();
        @(posedge core_clk);
        convert_start <= 1'b1;
        repeat (4) @(posedge core_clk);
        convert_start <= 1'b0;
    endtask : convert
    // ********************************************************
    // frame of n bits; upstream bits change after each fall
    // ********************************************************
    task automatic frame(input int n, input logic [15:0] up);
        int i;
        word = 32'h0000_0000;
        bus_enable_or_link_in = chain_mode ? up[15] : 1'b0;
        for (i = 0; i < n; i++)
        begin
            #62.5;
            word = {word[30:0], serial_out};
            shift_clk = 1'b1;
            #62.5;
            shift_clk = 1'b0;
            if (chain_mode)
                bus_enable_or_link_in = (i < 15) ? up[14-i] : ~up[0];
        end
        #62.5;
        bus_enable_or_link_in = chain_mode ? ~bus_enable_or_link_in : 1'b1;
        -> word_ev;
    endtask : frame
endmodule : host_model

// [test/sar_adc_serial_readout_tb.sv]
// Purpose: self-checking bench of the converter readout block
// Assumes: host model owns convert, shift clock and shared pin
// Notes:   drivers queue expected results, monitors compare them
`timescale 1ns/1ps
module sar_adc_serial_readout_tb;
    import sar_pkg::*;
    logic              core_clk, rst, avs_read, avs_write, chain_select;
    logic              avs_waitrequest, busy, serial_out, serial_out_oe, irq;
    logic              convert_start, shift_clk, bus_enable_or_link_in;
    logic [4:0]        avs_address;
    logic [31:0]       avs_writedata, avs_readdata, rd_data, word;
    logic [CODE_W-1:0] analog_level, code;
    logic [31:0]       reg_q[$], word_q[$];
    int                num_errors, comparisons, run, last_run, k;
    integer            seed = 32'h9aa4;
    event              rd_ev;
    sar_adc_serial_readout u_sar_adc_serial_readout (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .convert_start(convert_start),
        .chain_select(chain_select),
        .bus_enable_or_link_in(bus_enable_or_link_in),
        .shift_clk(shift_clk), .analog_level(analog_level), .busy(busy),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .irq(irq));
    host_model u_host_model (
        .core_clk(core_clk), .serial_out(serial_out),
        .chain_mode(chain_select), .convert_start(convert_start),
        .shift_clk(shift_clk),
        .bus_enable_or_link_in(bus_enable_or_link_in), .word(word));
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ********************************************************
    // compare tasks and monitors
    // ********************************************************
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : check_data
    task automatic check_count(input int got, input int exp);
        comparisons++;
        if (got != exp)
        begin
            num_errors++;
            $display("wrong value at %0t: count %0d, want %0d", $time, got, exp);
        end
    endtask : check_count
    always @(rd_ev) check_data(rd_data, reg_q.pop_front());
    always @(u_host_model.word_ev) check_data(word, word_q.pop_front());
    always @(posedge core_clk)
    begin
        if (busy === 1'b1)
            run <= run + 1;
        else if (run != 0)
        begin
            last_run <= run;
            run <= 0;
        end
    end
    // ********************************************************
    // bus, conversion and frame tasks
    // ********************************************************
    task automatic access(input logic wr, input logic [4:0] a,
                          input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        rd_data = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : access
    task automatic read_exp(input logic [4:0] a, input logic [31:0] e);
        reg_q.push_back(e);
        access(1'b0, a, 32'h0000_0000);
        -> rd_ev;
    endtask : read_exp
    task automatic conv(input int how, input logic [15:0] c);
        int i;
        analog_level <= c;
        if (how == 2) access(1'b1, OFS_CTRL, 32'h0000_0001);
        else u_host_model.convert();
        if (how == 1) access(1'b1, OFS_CTRL, 32'h0000_0001);
        for (i = 0; i < 300 && busy !== 1'b1; i++) @(posedge core_clk);
        check_data({31'h0, busy}, 32'h0000_0001);
        for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge core_clk);
        check_data({31'h0, busy}, 32'h0000_0000);
        @(posedge core_clk);
        check_count(last_run, 2 * CODE_W + 1);
        check_count(int'(last_run <= CONV_MAX_CYC), 1);
        read_exp(OFS_RESULT, {16'h0000, c});
    endtask : conv
    task automatic frame(input int n, input logic [31:0] e);
        word_q.push_back(e);
        fork
            u_host_model.frame(n, e[15:0]);
            begin
                repeat (12) @(posedge core_clk);
                check_data({31'h0, serial_out_oe}, 32'h0000_0001);
            end
        join
        @(posedge core_clk);
    endtask : frame
    task automatic complete_run();
        $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // ********************************************************
    // test sequence
    // ********************************************************
    initial
    begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0000_0000;
        chain_select = 1'b0;
        analog_level = 16'h0000;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2500) @(posedge core_clk);
        read_exp(OFS_STATUS, RDATA_RST);
        read_exp(OFS_IRQ_MK, {29'h0, IRQ_MASK_RST});
        read_exp(5'h14, RDATA_RST);
        check_data({31'h0, irq}, 32'h0000_0000);
        $display("test reset values done");
        for (k = 0; k < 7; k++)
        begin
            code = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff :
                   (k == 2) ? TRIAL_TOP : 16'($random(seed));
            conv((k == 3) ? 2 : 0, code);
            frame(16, {16'h0000, code});
        end
        repeat (4) @(posedge core_clk);
        check_data({31'h0, serial_out_oe}, 32'h0000_0000);
        $display("test normal mode done");
        access(1'b1, OFS_IRQ_MK, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        check_data({31'h0, irq}, 32'h0000_0001);
        access(1'b1, OFS_IRQ_ST, 32'h0000_0007);
        repeat (2) @(posedge core_clk);
        check_data({31'h0, irq}, 32'h0000_0000);
        conv(1, 16'h1234);
        read_exp(OFS_IRQ_ST, 32'h0000_0003);
        check_data({31'h0, irq}, 32'h0000_0001);
        $display("test interrupts done");
        chain_select <= 1'b1;
        repeat (4) @(posedge core_clk);
        read_exp(OFS_STATUS, 32'h0000_0002);
        code = 16'($random(seed));
        k = $random(seed);
        conv(0, code);
        frame(32, {code, k[15:0]});
        read_exp(OFS_IRQ_ST, 32'h0000_0007);
        $display("test chain mode done");
        complete_run();
    end
    initial
    begin
        #500_000;
        num_errors++;
        complete_run();
    end
endmodule : sar_adc_serial_readout_tb
